/* File: common/sbp_pkg.sv */
// Package: constants and types for the serial bus port status page
package sbp_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned SBP_CLK_HZ = 100_000_000;
	localparam int unsigned SBP_CON_DEB_MS = 341;
	localparam int unsigned SBP_CON_DEB_CYC = SBP_CON_DEB_MS * (SBP_CLK_HZ / 1000);
	localparam int unsigned SBP_BIAS_DEB_NS = 160;
	localparam int unsigned SBP_BIAS_DEB_CYC = (SBP_BIAS_DEB_NS * (SBP_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned SBP_DEB_W = 26;
	localparam int unsigned SBP_BDEB_W = 5;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [5:0] SBP_IDX_EVT = 6'h05;
	localparam logic [5:0] SBP_IDX_SEL = 6'h07;
	localparam logic [5:0] SBP_IDX_STAT = 6'h08;
	localparam logic [5:0] SBP_IDX_CTRL = 6'h09;
	localparam logic [5:0] SBP_IDX_SPD = 6'h0A;
	localparam logic [5:0] SBP_IDX_LAST = 6'h0F;

	// ==========================================================
	// Field positions
	localparam int unsigned SBP_ST_ARB_A = 6;
	localparam int unsigned SBP_ST_ARB_B = 4;
	localparam int unsigned SBP_ST_LEAF = 3;
	localparam int unsigned SBP_ST_CON = 2;
	localparam int unsigned SBP_ST_RECEIVE_GOOD = 1;
	localparam int unsigned SBP_ST_DIS = 0;
	localparam int unsigned SBP_CT_NSPD = 5;
	localparam int unsigned SBP_CT_PIE = 4;
	localparam int unsigned SBP_CT_FAULT = 3;
	localparam int unsigned SBP_CT_SBF = 2;
	localparam int unsigned SBP_CT_SCR = 1;
	localparam int unsigned SBP_CT_BONLY = 0;
	localparam int unsigned SBP_SP_DC = 7;
	localparam int unsigned SBP_SP_MAX = 4;
	localparam int unsigned SBP_SP_LPP = 3;
	localparam int unsigned SBP_SP_CAB = 0;
	localparam int unsigned SBP_SEL_PAGE = 5;
	localparam int unsigned SBP_SEL_PORT = 0;
	localparam int unsigned SBP_EVT_PEI = 0;

	// ==========================================================
	// Line states and speed codes
	localparam logic [1:0] SBP_ARB_Z = 2'h3;
	localparam logic [1:0] SBP_ARB_ONE = 2'h2;
	localparam logic [1:0] SBP_ARB_ZERO = 2'h1;
	localparam logic [1:0] SBP_ARB_INVALID = 2'h0;
	localparam logic [2:0] SBP_S100 = 3'h0;
	localparam logic [2:0] SBP_S200 = 3'h1;
	localparam logic [2:0] SBP_S400 = 3'h2;
	localparam logic [2:0] SBP_S800 = 3'h3;
	localparam logic [2:0] SBP_S1600 = 3'h4;
	localparam logic [2:0] SBP_S3200 = 3'h5;
	localparam logic [2:0] SBP_CABLE_SPEED = SBP_S800;
	localparam logic [3:0] SBP_PORT_COUNT = 4'h1;

	// ==========================================================
	// Synchronised pin vector layout
	localparam int unsigned SBP_SYN_W = 9;
	localparam int unsigned SBP_SY_ARB_A = 0;
	localparam int unsigned SBP_SY_ARB_B = 2;
	localparam int unsigned SBP_SY_CONN = 4;
	localparam int unsigned SBP_SY_TONE = 5;
	localparam int unsigned SBP_SY_BIAS = 6;
	localparam int unsigned SBP_SY_VALID = 7;
	localparam int unsigned SBP_SY_DC = 8;

	typedef enum logic [2:0] {
		SBP_CON_IDLE = 3'b001,
		SBP_CON_WAIT = 3'b010,
		SBP_CON_UP = 3'b100
	} sbp_con_st_t;

endpackage

/* File: src/sbp_port_status.sv */
// Module: serial bus port status page with APB register access
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module sbp_port_status import sbp_pkg::*; #(
	parameter int unsigned CON_DEBOUNCE_CYC = SBP_CON_DEB_CYC
) (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic PREADY_O,
	output logic [31:0] PRDATA_O,
	output logic PSLVERR_O,
	input wire logic [1:0] ARB_A_I,
	input wire logic [1:0] ARB_B_I,
	input wire logic PHYS_CONN_I,
	input wire logic TONES_I,
	input wire logic BIAS_I,
	input wire logic SIGNAL_VALID_I,
	input wire logic DC_DETECT_I,
	input wire logic BETA_MODE_I,
	input wire logic SPEED_NEG_DONE_I,
	input wire logic SPEED_LOAD_I,
	input wire logic [2:0] SPEED_VALUE_I,
	input wire logic IS_PARENT_I,
	input wire logic BUS_RESET_I,
	input wire logic TREE_ID_DONE_I,
	input wire logic SUSPENDED_I,
	input wire logic RESUMING_I,
	input wire logic SUSPENDING_I,
	input wire logic STANDBY_ERR_I,
	input wire logic STANDBY_EXIT_I,
	input wire logic STANDBY_CLR_CMD_I,
	input wire logic PORT_EVENT_I,
	output logic ACTIVE_ALLOW_O,
	output logic PEER_ATTACHED_O,
	output logic RECEIVE_GOOD_O,
	output logic HOLD_SUSPEND_O,
	output logic STANDBY_ERR_CLR_O,
	output logic SCRAMBLE_OFF_O,
	output logic PORT_EVENT_IRQ_FLAG_O,
	output logic LINK_NOTIFY_O,
	output logic [2:0] MAX_PORT_SPEED_O
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [SBP_SYN_W-1:0] sy1;
		logic [SBP_SYN_W-1:0] sy2;
		logic [SBP_SYN_W-1:0] sy3;
		logic [SBP_SYN_W-1:0] filt;
		sbp_con_st_t con_st;
		logic [SBP_DEB_W-1:0] deb_cnt;
		logic [SBP_BDEB_W-1:0] bias_cnt;
		logic bias_deb;
		logic tree_done;
		logic dis;
		logic port_event_irq_enable;
		logic port_event_irq_flag;
		logic fault;
		logic sb_fault;
		logic scr_off;
		logic [2:0] neg_speed;
		logic [2:0] max_speed;
		logic [2:0] page;
		logic [3:0] port;
		logic [31:0] prdata;
		logic slverr;
		logic sb_clr;
		logic notify;
	} sbp_state_t;

	sbp_state_t state_r;
	sbp_state_t state_nxt;

	function automatic logic [5:0] reg_index(input logic [7:0] addr);
		reg_index = addr[7:2];
	endfunction

	function automatic logic mapped(input logic [5:0] idx);
		mapped = (idx == SBP_IDX_EVT) || (idx == SBP_IDX_SEL) ||
			((idx >= SBP_IDX_STAT) && (idx <= SBP_IDX_LAST));
	endfunction

	// ==========================================================
	// Derived status
	logic beta;
	logic con;
	logic receive_good;
	logic leaf;
	logic page_vis;
	logic fault_evt;
	logic wr_acc;
	logic fault_clr_wr;
	logic rd_setup;
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;
	logic [31:0] rd_word;

	assign beta = BETA_MODE_I;
	assign con = (state_r.con_st == SBP_CON_UP);
	// Tones alone never count as a good receive in beta mode
	assign receive_good = beta ? (state_r.filt[SBP_SY_VALID] & ~state_r.filt[SBP_SY_TONE]) : state_r.bias_deb;
	// Until tree identification ends the parent indication is untrusted, so report child
	assign leaf = ~con | state_r.dis | SUSPENDED_I | ~state_r.tree_done | ~IS_PARENT_I;
	assign page_vis = (state_r.page == 3'h0) && (state_r.port < SBP_PORT_COUNT);
	assign fault_evt = (RESUMING_I & ~state_r.filt[SBP_SY_BIAS]) | (SUSPENDING_I & state_r.filt[SBP_SY_BIAS]);
	assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
	assign fault_clr_wr = wr_acc && (wr_idx == SBP_IDX_CTRL) && page_vis && PWDATA_I[SBP_CT_FAULT];
	assign rd_setup = PSEL_I & ~PENABLE_I;
	assign wr_idx = reg_index(PADDR_I);
	assign rd_idx = reg_index(PADDR_I);

	// ==========================================================
	// Read multiplexer
	always_comb begin
		rd_word = 32'h0000_0000;
		case (rd_idx)
			SBP_IDX_EVT: rd_word[SBP_EVT_PEI] = state_r.port_event_irq_flag;
			SBP_IDX_SEL: begin
				rd_word[SBP_SEL_PAGE +: 3] = state_r.page;
				rd_word[SBP_SEL_PORT +: 4] = state_r.port;
			end
			SBP_IDX_STAT: begin
				if (page_vis) begin
					rd_word[SBP_ST_ARB_A +: 2] = state_r.filt[SBP_SY_ARB_A +: 2];
					rd_word[SBP_ST_ARB_B +: 2] = state_r.filt[SBP_SY_ARB_B +: 2];
					rd_word[SBP_ST_LEAF] = leaf;
					rd_word[SBP_ST_CON] = con;
					rd_word[SBP_ST_RECEIVE_GOOD] = receive_good;
					rd_word[SBP_ST_DIS] = state_r.dis;
				end
			end
			SBP_IDX_CTRL: begin
				if (page_vis) begin
					rd_word[SBP_CT_NSPD +: 3] = state_r.neg_speed;
					rd_word[SBP_CT_PIE] = state_r.port_event_irq_enable;
					rd_word[SBP_CT_FAULT] = state_r.fault;
					rd_word[SBP_CT_SBF] = state_r.sb_fault;
					rd_word[SBP_CT_SCR] = state_r.scr_off;
					rd_word[SBP_CT_BONLY] = 1'b0;
				end
			end
			SBP_IDX_SPD: begin
				if (page_vis) begin
					rd_word[SBP_SP_DC] = state_r.filt[SBP_SY_DC];
					rd_word[SBP_SP_MAX +: 3] = state_r.max_speed;
					rd_word[SBP_SP_LPP] = 1'b1;
					rd_word[SBP_SP_CAB +: 3] = SBP_CABLE_SPEED;
				end
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		state_nxt.sb_clr = 1'b0;
		state_nxt.notify = 1'b0;

		// Three-stage synchroniser; a change counts when stages two and three agree
		state_nxt.sy1 = {DC_DETECT_I, SIGNAL_VALID_I, BIAS_I, TONES_I, PHYS_CONN_I, ARB_B_I, ARB_A_I};
		state_nxt.sy2 = state_r.sy1;
		state_nxt.sy3 = state_r.sy2;
		for (int i = 0; i < SBP_SYN_W; i++) begin
			if (state_r.sy2[i] == state_r.sy3[i]) begin
				state_nxt.filt[i] = state_r.sy3[i];
			end
		end

		// Connection debounce
		case (state_r.con_st)
			SBP_CON_IDLE: begin
				state_nxt.deb_cnt = '0;
				if (beta) begin
					if (state_r.filt[SBP_SY_TONE] && SPEED_NEG_DONE_I) begin
						state_nxt.con_st = SBP_CON_UP;
					end
				end else if (state_r.filt[SBP_SY_CONN]) begin
					state_nxt.con_st = SBP_CON_WAIT;
				end
			end
			SBP_CON_WAIT: begin
				if (!state_r.filt[SBP_SY_CONN] || beta) begin
					state_nxt.con_st = SBP_CON_IDLE;
				end else if (state_r.deb_cnt == SBP_DEB_W'(CON_DEBOUNCE_CYC - 1)) begin
					state_nxt.con_st = SBP_CON_UP;
				end else begin
					state_nxt.deb_cnt = state_r.deb_cnt + 1'b1;
				end
			end
			SBP_CON_UP: begin
				// Bus reset does not drop the attachment; only loss of the cable does
				if (beta ? !state_r.filt[SBP_SY_TONE] && !state_r.filt[SBP_SY_VALID]
					: !state_r.filt[SBP_SY_CONN]) begin
					state_nxt.con_st = SBP_CON_IDLE;
				end
			end
			default: state_nxt.con_st = SBP_CON_IDLE;
		endcase

		// Legacy bias debounce
		if (state_r.filt[SBP_SY_BIAS] == state_r.bias_deb) begin
			state_nxt.bias_cnt = '0;
		end else if (state_r.bias_cnt == SBP_BDEB_W'(SBP_BIAS_DEB_CYC - 1)) begin
			state_nxt.bias_deb = state_r.filt[SBP_SY_BIAS];
			state_nxt.bias_cnt = '0;
		end else begin
			state_nxt.bias_cnt = state_r.bias_cnt + 1'b1;
		end

		// Tree identification tracking
		if (BUS_RESET_I) begin
			state_nxt.tree_done = 1'b0;
		end else if (TREE_ID_DONE_I) begin
			state_nxt.tree_done = 1'b1;
		end

		// Agreed speed; reserved codes are not stored
		if (SPEED_LOAD_I && (SPEED_VALUE_I <= SBP_S3200)) begin
			state_nxt.neg_speed = SPEED_VALUE_I;
		end

		// Register writes; of the status fields only dis has a write path
		if (wr_acc) begin
			case (wr_idx)
				SBP_IDX_EVT: begin
					if (PWDATA_I[SBP_EVT_PEI]) begin
						state_nxt.port_event_irq_flag = 1'b0;
					end
				end
				SBP_IDX_SEL: begin
					state_nxt.page = PWDATA_I[SBP_SEL_PAGE +: 3];
					state_nxt.port = PWDATA_I[SBP_SEL_PORT +: 4];
				end
				SBP_IDX_STAT: begin
					if (page_vis) begin
						state_nxt.dis = PWDATA_I[SBP_ST_DIS];
					end
				end
				SBP_IDX_CTRL: begin
					if (page_vis) begin
						state_nxt.port_event_irq_enable = PWDATA_I[SBP_CT_PIE];
						state_nxt.scr_off = PWDATA_I[SBP_CT_SCR];
						if (PWDATA_I[SBP_CT_FAULT]) begin
							state_nxt.fault = 1'b0;
						end
						if (PWDATA_I[SBP_CT_SBF] && state_r.sb_fault) begin
							state_nxt.sb_fault = 1'b0;
							state_nxt.sb_clr = 1'b1;
						end
					end
				end
				SBP_IDX_SPD: begin
					// A speed above the cable's ability saturates to it
					if (page_vis) begin
						state_nxt.max_speed = (PWDATA_I[SBP_SP_MAX +: 3] > SBP_CABLE_SPEED) ?
							SBP_CABLE_SPEED : PWDATA_I[SBP_SP_MAX +: 3];
					end
				end
				default: state_nxt.dis = state_r.dis;
			endcase
		end

		// Standby fault clears; hardware set wins over any clear
		if ((STANDBY_EXIT_I || STANDBY_CLR_CMD_I) && state_r.sb_fault) begin
			state_nxt.sb_fault = 1'b0;
			state_nxt.sb_clr = 1'b1;
		end
		if (STANDBY_ERR_I) begin
			state_nxt.sb_fault = 1'b1;
			state_nxt.sb_clr = 1'b0;
		end
		if (fault_evt) begin
			state_nxt.fault = 1'b1;
		end
		if (PORT_EVENT_I && state_r.port_event_irq_enable) begin
			state_nxt.port_event_irq_flag = 1'b1;
			state_nxt.notify = 1'b1;
		end

		// Read data captured in setup so the answer leaves a flop
		if (rd_setup) begin
			state_nxt.prdata = PWRITE_I ? 32'h0000_0000 : rd_word;
			state_nxt.slverr = ~mapped(rd_idx);
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= '0;
			state_r.con_st <= SBP_CON_IDLE;
			state_r.max_speed <= SBP_CABLE_SPEED;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign PREADY_O = 1'b1;
	assign PRDATA_O = state_r.prdata;
	assign PSLVERR_O = PSEL_I & PENABLE_I & state_r.slverr;
	assign ACTIVE_ALLOW_O = con & receive_good & ~state_r.dis;
	assign PEER_ATTACHED_O = con;
	assign RECEIVE_GOOD_O = receive_good;
	assign HOLD_SUSPEND_O = state_r.fault;
	assign STANDBY_ERR_CLR_O = state_r.sb_clr;
	assign SCRAMBLE_OFF_O = state_r.scr_off;
	assign PORT_EVENT_IRQ_FLAG_O = state_r.port_event_irq_flag;
	assign LINK_NOTIFY_O = state_r.notify;
	assign MAX_PORT_SPEED_O = state_r.max_speed;

	// ==========================================================
	// Checks
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	a_receive_good_tones_only: assert property (beta && state_r.filt[SBP_SY_TONE] |-> !RECEIVE_GOOD_O)
		else $error("receive good with tones only");
	a_child_when_down: assert property (!PEER_ATTACHED_O || state_r.dis || SUSPENDED_I |-> leaf)
		else $error("unattached port not reported as child");
	a_con_debounce: assert property ($rose(con) && !$past(beta) && $past(state_r.con_st) == SBP_CON_WAIT
		|-> $past(state_r.deb_cnt) == SBP_DEB_W'(CON_DEBOUNCE_CYC - 1))
		else $error("attach before debounce expired");
	a_shutoff_inactive: assert property (state_r.dis |-> !ACTIVE_ALLOW_O)
		else $error("disabled port allowed active");
	// A clear write in the first held cycle may legally drop the flag
	a_fault_set: assert property (fault_evt |=> HOLD_SUSPEND_O ##1 (HOLD_SUSPEND_O || $past(fault_clr_wr)))
		else $error("fault not held after event");
	a_fault_clear: assert property (fault_clr_wr && !fault_evt |=> !state_r.fault)
		else $error("fault not cleared by write one");
	a_standby_exit: assert property (STANDBY_EXIT_I && !STANDBY_ERR_I && state_r.sb_fault
		|=> !state_r.sb_fault && STANDBY_ERR_CLR_O)
		else $error("standby fault not cleared on exit");
	a_event_notify: assert property (PORT_EVENT_I && state_r.port_event_irq_enable |=> PORT_EVENT_IRQ_FLAG_O && LINK_NOTIFY_O)
		else $error("port event not flagged");
	a_absent_port_zero: assert property (rd_setup && !PWRITE_I && rd_idx >= SBP_IDX_STAT && !page_vis
		|=> PRDATA_O == 32'h0000_0000)
		else $error("unselected page read nonzero");
	a_beta_only_zero: assert property (rd_setup && !PWRITE_I && rd_idx == SBP_IDX_CTRL
		|=> !PRDATA_O[SBP_CT_BONLY])
		else $error("beta-only flag read as one");

	c_attach: cover property ($rose(con));
	c_fault: cover property ($rose(state_r.fault));
	c_event: cover property ($rose(state_r.port_event_irq_flag));
	c_shutoff: cover property ($rose(state_r.dis));

endmodule // sbp_port_status

`default_nettype wire

/* File: sim/sbp_peer_phy.sv */
// Peer PHY model standing across the cable from the port
`timescale 1ns/1ns
`default_nettype none
module sbp_peer_phy (
	input wire logic clk_i,
	input wire logic [1:0] mode_i,
	input wire logic [3:0] arb_i,
	input wire logic dc_i,
	output logic [1:0] arb_a_o,
	output logic [1:0] arb_b_o,
	output logic conn_o,
	output logic tones_o,
	output logic bias_o,
	output logic valid_o,
	output logic dc_o
);
	// ==========================================================
	// Modes: 0 unplugged, 1 legacy, 2 beta tones only, 3 beta active
	always_ff @(posedge clk_i) begin
		arb_a_o <= arb_i[3:2];
		arb_b_o <= arb_i[1:0];
		conn_o <= (mode_i == 2'h1);
		// Unplugged bias falls to its pull-down level, not the last value
		bias_o <= (mode_i == 2'h1);
		tones_o <= (mode_i == 2'h2);
		valid_o <= (mode_i == 2'h3);
		dc_o <= dc_i;
	end
endmodule // sbp_peer_phy
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking testbench for the port status page
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s expected %h seen %h", nm, (e), (g)); end end
module testbench import sbp_pkg::*; ;
	localparam int unsigned DEB = 20;
	int n_mismatch = 0;
	int checks_done = 0;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, serr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rdata, prdata;
	logic pready, pslverr, beta = 1'b0, neg = 1'b0, sload = 1'b0, spar = 1'b0, busrst = 1'b0;
	logic treedone = 1'b0, susp = 1'b0, resm = 1'b0, suspg = 1'b0, sberr = 1'b0, sbexit = 1'b0;
	logic sbcmd = 1'b0, pev = 1'b0, dc = 1'b0;
	logic [2:0] sval = 3'h0;
	logic [1:0] mode = 2'h0;
	logic [3:0] arb = 4'hF;
	logic [1:0] a_a, a_b;
	logic conn, tones, bias, valid, dcw, act, peer_att, rxg, hold, sbclr, scr, port_event_irq_flag, notify;
	logic [2:0] maxsp;

	always #5 clk = ~clk;

	sbp_peer_phy peer (.clk_i(clk), .mode_i(mode), .arb_i(arb), .dc_i(dc), .arb_a_o(a_a), .arb_b_o(a_b),
		.conn_o(conn), .tones_o(tones), .bias_o(bias), .valid_o(valid), .dc_o(dcw));

	sbp_port_status #(.CON_DEBOUNCE_CYC(DEB)) dut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
		.PRDATA_O(prdata), .PSLVERR_O(pslverr), .ARB_A_I(a_a), .ARB_B_I(a_b), .PHYS_CONN_I(conn),
		.TONES_I(tones), .BIAS_I(bias), .SIGNAL_VALID_I(valid), .DC_DETECT_I(dcw), .BETA_MODE_I(beta),
		.SPEED_NEG_DONE_I(neg), .SPEED_LOAD_I(sload), .SPEED_VALUE_I(sval), .IS_PARENT_I(spar),
		.BUS_RESET_I(busrst), .TREE_ID_DONE_I(treedone), .SUSPENDED_I(susp), .RESUMING_I(resm),
		.SUSPENDING_I(suspg), .STANDBY_ERR_I(sberr), .STANDBY_EXIT_I(sbexit),
		.STANDBY_CLR_CMD_I(sbcmd), .PORT_EVENT_I(pev), .ACTIVE_ALLOW_O(act),
		.PEER_ATTACHED_O(peer_att), .RECEIVE_GOOD_O(rxg), .HOLD_SUSPEND_O(hold),
		.STANDBY_ERR_CLR_O(sbclr), .SCRAMBLE_OFF_O(scr), .PORT_EVENT_IRQ_FLAG_O(port_event_irq_flag),
		.LINK_NOTIFY_O(notify), .MAX_PORT_SPEED_O(maxsp));

	// ==========================================================
	// Bus tasks; the master never assumes a wait count
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) n_mismatch++;
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] e, input string nm);
		apb(1'b0, idx, 32'h0);
		`CHK(nm, {24'h0, e}, rdata)
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {24'h0, d});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic end_sim();
		if (n_mismatch == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		n_mismatch++;
		end_sim();
	end

	// ==========================================================
	// Test sequence
	initial begin
		cyc(2);
		rst <= 1'b0;
		cyc(2);
		for (int i = 0; i < 4; i++) begin
			arb <= {i[1:0], ~i[1:0]};
			cyc(6);
			rd(SBP_IDX_STAT, {i[1:0], ~i[1:0], 4'h8}, "stat_lines");
		end
		rd(SBP_IDX_CTRL, 8'h00, "ctrl_reset");
		rd(SBP_IDX_SPD, 8'h3B, "spd_reset");
		wr(SBP_IDX_STAT, 8'hFF);
		rd(SBP_IDX_STAT, 8'hC9, "stat_ro_write");
		wr(SBP_IDX_CTRL, 8'hFF);
		rd(SBP_IDX_CTRL, 8'h12, "ctrl_ro_write");
		`CHK("scramble_off", 1'b1, scr)
		wr(SBP_IDX_CTRL, 8'h00);
		wr(SBP_IDX_SEL, 8'h20);
		rd(SBP_IDX_STAT, 8'h00, "other_page");
		wr(SBP_IDX_SEL, 8'h01);
		rd(SBP_IDX_STAT, 8'h00, "absent_port");
		wr(SBP_IDX_SEL, 8'h00);
		apb(1'b0, 6'h00, 32'h0);
		`CHK("unmapped_err", 1'b1, serr)
		// Legacy connection with the port shut off
		mode <= 2'h1;
		cyc(20);
		`CHK("con_early", 1'b0, peer_att)
		cyc(20);
		`CHK("con_late", 1'b1, peer_att)
		`CHK("rx_bias", 1'b1, rxg)
		`CHK("shut_inactive", 1'b0, act)
		wr(SBP_IDX_STAT, 8'h00);
		cyc(2);
		`CHK("enabled_active", 1'b1, act)
		// Child bit around bus reset and tree identification
		spar <= 1'b1;
		busrst <= 1'b1;
		@(posedge clk);
		busrst <= 1'b0;
		rd(SBP_IDX_STAT, 8'hCE, "leaf_before_tree");
		treedone <= 1'b1;
		@(posedge clk);
		treedone <= 1'b0;
		rd(SBP_IDX_STAT, 8'hC6, "parent_port");
		wr(SBP_IDX_STAT, 8'h01);
		rd(SBP_IDX_STAT, 8'hCF, "disabled_child");
		wr(SBP_IDX_STAT, 8'h00);
		susp <= 1'b1;
		rd(SBP_IDX_STAT, 8'hCE, "suspended_child");
		susp <= 1'b0;
		busrst <= 1'b1;
		@(posedge clk);
		busrst <= 1'b0;
		rd(SBP_IDX_STAT, 8'hCE, "leaf_after_bus_reset");
		// Port events, masked then enabled
		for (int k = 0; k < 2; k++) begin
			wr(SBP_IDX_CTRL, {3'h0, k[0], 4'h0});
			pev <= 1'b1;
			@(posedge clk);
			pev <= 1'b0;
			@(posedge clk);
			`CHK("link_notify", k[0], notify)
			`CHK("event_irq_flag", k[0], port_event_irq_flag)
			rd(SBP_IDX_EVT, {7'h0, k[0]}, "event_flag");
		end
		wr(SBP_IDX_EVT, 8'h01);
		rd(SBP_IDX_EVT, 8'h00, "event_clear");
		// Suspend fault while bias is still seen, then resume fault without bias
		for (int k = 0; k < 2; k++) begin
			mode <= k[0] ? 2'h0 : 2'h1;
			cyc(8);
			suspg <= ~k[0];
			resm <= k[0];
			@(posedge clk);
			suspg <= 1'b0;
			resm <= 1'b0;
			@(posedge clk);
			`CHK("hold_suspend", 1'b1, hold)
			rd(SBP_IDX_CTRL, 8'h18, "fault_set");
			wr(SBP_IDX_CTRL, 8'h18);
			rd(SBP_IDX_CTRL, 8'h10, "fault_clear");
		end
		// Standby fault cleared by exit, remote command and write of one
		for (int k = 0; k < 3; k++) begin
			sberr <= 1'b1;
			@(posedge clk);
			sberr <= 1'b0;
			rd(SBP_IDX_CTRL, 8'h14, "standby_set");
			if (k == 2) wr(SBP_IDX_CTRL, 8'h14);
			else begin
				sbexit <= (k == 0);
				sbcmd <= (k == 1);
				@(posedge clk);
				sbexit <= 1'b0;
				sbcmd <= 1'b0;
			end
			@(posedge clk);
			`CHK("standby_clr_pulse", 1'b1, sbclr)
			rd(SBP_IDX_CTRL, 8'h10, "standby_clear");
		end
		// Every speed code, reserved ones must not load
		for (int c = 0; c < 8; c++) begin
			sval <= c[2:0];
			sload <= 1'b1;
			@(posedge clk);
			sload <= 1'b0;
			rd(SBP_IDX_CTRL, {(c < 6) ? c[2:0] : SBP_S3200, 5'h10}, "agreed_speed");
		end
		wr(SBP_IDX_SPD, 8'h70);
		dc <= 1'b1;
		cyc(8);
		rd(SBP_IDX_SPD, 8'hBB, "dc_and_speed_cap");
		`CHK("max_speed_sat", SBP_CABLE_SPEED, maxsp)
		wr(SBP_IDX_SPD, 8'h10);
		rd(SBP_IDX_SPD, 8'h9B, "max_speed_low");
		`CHK("max_speed_out", SBP_S200, maxsp)
		// Beta connection: tones alone, then negotiation, then valid signal
		beta <= 1'b1;
		mode <= 2'h2;
		cyc(10);
		`CHK("beta_no_neg", 1'b0, peer_att)
		neg <= 1'b1;
		cyc(4);
		`CHK("beta_con", 1'b1, peer_att)
		`CHK("tones_rx_off", 1'b0, rxg)
		mode <= 2'h3;
		cyc(10);
		`CHK("beta_rx_valid", 1'b1, rxg)
		// Hardware reset in mid-run
		wr(SBP_IDX_STAT, 8'h01);
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(8);
		rd(SBP_IDX_STAT, 8'hCA, "stat_hw_reset");
		rd(SBP_IDX_CTRL, 8'h00, "ctrl_hw_reset");
		`CHK("max_speed_hw_reset", SBP_CABLE_SPEED, maxsp)
		end_sim();
	end
endmodule // testbench
`default_nettype wire
